// *** fpdo_fifo.sv ***
// small valid/ready buffer for outgoing telegrams
`timescale 1ns/1ns
`default_nettype none
module fpdo_fifo #(
    parameter int unsigned WIDTH = 66,
    parameter int unsigned DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output var  logic             in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output var  logic             out_valid,
    input  wire logic             out_ready,
    output var  logic [WIDTH-1:0] out_data
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             valid_reg;
    logic             push;
    logic             pop;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("fpdo_fifo: DEPTH must be a power of two of at least 2");
    end

    // the head always sits in slot 0, so the outputs come straight from registers
    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = valid_reg;
    assign out_data  = mem[0];
    assign push      = in_valid && in_ready;
    assign pop       = valid_reg && out_ready;

    always_comb begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + (AW+1)'(1);
        end else if (pop && !push) begin
            count_next = count_reg - (AW+1)'(1);
        end
    end

    // a pop shifts every entry one slot down; a push lands behind the last kept entry
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_slot
            always_ff @(posedge clk) begin
                if (rst) begin
                    mem[gi] <= '0;
                end else if (push && count_next == (AW+1)'(gi + 1)) begin
                    mem[gi] <= in_data;
                end else if (pop) begin
                    mem[gi] <= mem[(gi + 1) % DEPTH];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (rst) begin
            count_reg <= '0;
            valid_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            valid_reg <= (count_next != '0);
        end
    end
endmodule
`default_nettype wire

// *** fpdo_framer.sv ***
// process data object framer: cyclic and event objects between drive and bus
`timescale 1ns/1ns
`default_nettype none
module fpdo_framer #(
    parameter int unsigned MS_CYCLES = fpdo_pkg::MS_CYCLES
) (
    input  wire logic                       SYS_CLK,
    input  wire logic                       RST,
    input  wire logic                       OPERATIONAL,
    input  wire logic                       RX_VALID,
    input  wire fpdo_pkg::fpdo_rx_frame_s   RX_FRAME,
    output var  logic                       TX_VALID,
    input  wire logic                       TX_READY,
    output var  fpdo_pkg::fpdo_tx_frame_s   TX_FRAME,
    input  wire fpdo_pkg::fpdo_cyc_tx_src_s CYC_TX_SRC,
    input  wire fpdo_pkg::fpdo_src_e        CYC_TX_SEL_LO,
    input  wire fpdo_pkg::fpdo_src_e        CYC_TX_SEL_HI,
    input  wire logic [63:0]                EVT_TX_A_DATA,
    input  wire logic [63:0]                EVT_TX_B_DATA,
    input  wire logic [15:0]                EVT_TX_A_CYCLE_MS,
    input  wire logic [15:0]                EVT_TX_B_CYCLE_MS,
    input  wire logic [15:0]                EVT_RX_A_MONITOR_MS,
    input  wire logic [15:0]                EVT_RX_B_MONITOR_MS,
    output var  fpdo_pkg::fpdo_cyc_rx_s     CYC_RX,
    output var  fpdo_pkg::fpdo_evt_rx_s     EVT_RX_A,
    output var  fpdo_pkg::fpdo_evt_rx_s     EVT_RX_B,
    output var  logic                       EVT_RX_A_FAULT,
    output var  logic                       EVT_RX_B_FAULT
);
    localparam int unsigned MSW = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;
    localparam int unsigned NE  = fpdo_pkg::EVT_OBJECTS;
    localparam int unsigned FW  = $bits(fpdo_pkg::fpdo_tx_frame_s);

    if (MS_CYCLES < 2) begin : g_bad_ms
        $error("fpdo_framer: MS_CYCLES must be at least 2");
    end

    // byte pair picker for the selectable half of the cyclic tx payload
    function automatic logic [15:0] pick_src(input fpdo_pkg::fpdo_src_e sel,
                                             input logic [15:0] word,
                                             input logic [15:0] bits16,
                                             input logic [15:0] dw16);
        case (sel)
            fpdo_pkg::FPDO_SRC_WORD:  pick_src = word;
            fpdo_pkg::FPDO_SRC_BITS:  pick_src = bits16;
            fpdo_pkg::FPDO_SRC_DWORD: pick_src = dw16;
            default:                  pick_src = word;
        endcase
    endfunction

    // event rx decoding, shared by both event objects
    function automatic fpdo_pkg::fpdo_evt_rx_s decode_evt(input logic [63:0] d);
        fpdo_pkg::fpdo_evt_rx_s r;
        r       = '0;
        r.word1 = d[fpdo_pkg::EVT_W1_LSB +: 16];
        r.word2 = d[fpdo_pkg::EVT_W2_LSB +: 16];
        r.word3 = d[fpdo_pkg::EVT_W3_LSB +: 16];
        r.word4 = d[fpdo_pkg::EVT_W4_LSB +: 16];
        r.bits  = d[fpdo_pkg::EVT_DW_LSB +: 32];
        r.dword = d[fpdo_pkg::EVT_DW_LSB +: 32];
        decode_evt = r;
    endfunction

    // ---------------- receive side ----------------
    logic        rx_hit;
    logic        sync_hit;
    logic        cyc_rx_hit;
    logic [NE-1:0] evt_rx_hit;
    logic [63:0] cyc_shadow_reg;
    logic [63:0] cyc_active_reg;
    logic [63:0] evt_rx_reg [NE];

    assign rx_hit        = RX_VALID && OPERATIONAL;
    assign sync_hit      = rx_hit && RX_FRAME.kind == fpdo_pkg::FPDO_RX_SYNC;
    assign cyc_rx_hit    = rx_hit && RX_FRAME.kind == fpdo_pkg::FPDO_RX_CYCLIC;
    assign evt_rx_hit[0] = rx_hit && RX_FRAME.kind == fpdo_pkg::FPDO_RX_EVENT_A;
    assign evt_rx_hit[1] = rx_hit && RX_FRAME.kind == fpdo_pkg::FPDO_RX_EVENT_B;

    // cyclic data arriving between syncs only waits in the shadow copy
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            cyc_shadow_reg <= fpdo_pkg::PAYLOAD_RST;
        end else if (cyc_rx_hit) begin
            cyc_shadow_reg <= RX_FRAME.data;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            cyc_active_reg <= fpdo_pkg::PAYLOAD_RST;
        end else if (sync_hit) begin
            cyc_active_reg <= cyc_shadow_reg;
        end
    end

    // cyclic rx views, all taken from the same active bytes
    always_comb begin
        CYC_RX           = '0;
        CYC_RX.ctrl_word = cyc_active_reg[fpdo_pkg::CTRL_LSB +: 16];
        CYC_RX.word1     = cyc_active_reg[fpdo_pkg::CYC_W1_LSB +: 16];
        CYC_RX.word2     = cyc_active_reg[fpdo_pkg::CYC_W2_LSB +: 16];
        CYC_RX.word3     = cyc_active_reg[fpdo_pkg::CYC_W3_LSB +: 16];
        CYC_RX.bits      = cyc_active_reg[fpdo_pkg::CYC_DW_LSB +: 32];
        CYC_RX.dword     = cyc_active_reg[fpdo_pkg::CYC_DW_LSB +: 32];
    end

    // event rx objects bypass the sync and apply immediately
    genvar gi;
    generate
        for (gi = 0; gi < NE; gi++) begin : g_evt_rx
            always_ff @(posedge SYS_CLK) begin
                if (RST) begin
                    evt_rx_reg[gi] <= fpdo_pkg::PAYLOAD_RST;
                end else if (evt_rx_hit[gi]) begin
                    evt_rx_reg[gi] <= RX_FRAME.data;
                end
            end
        end
    endgenerate

    assign EVT_RX_A = decode_evt(evt_rx_reg[0]);
    assign EVT_RX_B = decode_evt(evt_rx_reg[1]);

    // ---------------- millisecond tick ----------------
    logic [MSW-1:0] ms_cnt_reg;
    logic           ms_tick_reg;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            ms_cnt_reg  <= '0;
            ms_tick_reg <= 1'b0;
        end else if (ms_cnt_reg == MSW'(MS_CYCLES - 1)) begin
            ms_cnt_reg  <= '0;
            ms_tick_reg <= 1'b1;
        end else begin
            ms_cnt_reg  <= ms_cnt_reg + MSW'(1);
            ms_tick_reg <= 1'b0;
        end
    end

    // ---------------- monitoring of event rx ----------------
    logic [15:0]   rx_mon_ms [NE];
    logic [NE-1:0] rx_mon_expired;
    logic [NE-1:0] rx_fault_reg;

    assign rx_mon_ms[0] = EVT_RX_A_MONITOR_MS;
    assign rx_mon_ms[1] = EVT_RX_B_MONITOR_MS;

    generate
        for (gi = 0; gi < NE; gi++) begin : g_rx_mon
            // the watch only runs while operational; each telegram of its own event object rewinds it
            fpdo_interval #(.TW(fpdo_pkg::TIME_W)) u_mon (
                .clk     (SYS_CLK),
                .rst     (RST),
                .tick    (ms_tick_reg),
                .period  (rx_mon_ms[gi]),
                .restart (evt_rx_hit[gi] || !OPERATIONAL),
                .expired (rx_mon_expired[gi])
            );

            // a fresh telegram clears the fault; if expiry lands in the same cycle, the fault wins
            always_ff @(posedge SYS_CLK) begin
                if (RST) begin
                    rx_fault_reg[gi] <= 1'b0;
                end else if (rx_mon_expired[gi]) begin
                    rx_fault_reg[gi] <= 1'b1;
                end else if (evt_rx_hit[gi]) begin
                    rx_fault_reg[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    assign EVT_RX_A_FAULT = rx_fault_reg[0];
    assign EVT_RX_B_FAULT = rx_fault_reg[1];

    // ---------------- transmit side ----------------
    logic        cyc_pend_reg;
    logic [63:0] cyc_payload_reg;
    logic [63:0] cyc_build;
    logic [63:0] evt_tx_data [NE];
    logic [63:0] evt_last_reg [NE];
    logic [15:0] tx_cycle_ms [NE];
    logic [NE-1:0] tx_cycle_expired;
    logic [NE-1:0] evt_due_reg;
    logic [NE-1:0] evt_req;
    logic [NE-1:0] evt_take;
    logic        cyc_take;
    logic        buf_in_valid;
    logic        buf_in_ready;
    fpdo_pkg::fpdo_tx_frame_s buf_in_frame;

    assign evt_tx_data[0] = EVT_TX_A_DATA;
    assign evt_tx_data[1] = EVT_TX_B_DATA;
    assign tx_cycle_ms[0] = EVT_TX_A_CYCLE_MS;
    assign tx_cycle_ms[1] = EVT_TX_B_CYCLE_MS;

    always_comb begin
        cyc_build         = '0;
        cyc_build[fpdo_pkg::CTRL_LSB +: 16]   = CYC_TX_SRC.status_word;
        cyc_build[fpdo_pkg::CYC_W1_LSB +: 16] = CYC_TX_SRC.word1;
        cyc_build[fpdo_pkg::CYC_W2_LSB +: 16] = pick_src(CYC_TX_SEL_LO, CYC_TX_SRC.word2,
                                                         CYC_TX_SRC.bits[15:0],
                                                         CYC_TX_SRC.dword[15:0]);
        cyc_build[fpdo_pkg::CYC_W3_LSB +: 16] = pick_src(CYC_TX_SEL_HI, CYC_TX_SRC.word3,
                                                         CYC_TX_SRC.bits[31:16],
                                                         CYC_TX_SRC.dword[31:16]);
    end

    // snapshot at the sync so that a later stall cannot mix old and new values
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            cyc_pend_reg    <= 1'b0;
            cyc_payload_reg <= fpdo_pkg::PAYLOAD_RST;
        end else if (!OPERATIONAL) begin
            cyc_pend_reg    <= 1'b0;
        end else if (sync_hit) begin
            cyc_pend_reg    <= 1'b1;
            cyc_payload_reg <= cyc_build;
        end else if (cyc_take) begin
            cyc_pend_reg    <= 1'b0;
        end
    end

    generate
        for (gi = 0; gi < NE; gi++) begin : g_evt_tx
            assign evt_req[gi] = evt_due_reg[gi] || (evt_tx_data[gi] != evt_last_reg[gi]);

            fpdo_interval #(.TW(fpdo_pkg::TIME_W)) u_cycle (
                .clk     (SYS_CLK),
                .rst     (RST),
                .tick    (ms_tick_reg),
                .period  (tx_cycle_ms[gi]),
                .restart (evt_take[gi] || !OPERATIONAL),
                .expired (tx_cycle_expired[gi])
            );

            // expiry waits here while the buffer is busy; a send consumes it
            always_ff @(posedge SYS_CLK) begin
                if (RST || !OPERATIONAL) begin
                    evt_due_reg[gi] <= 1'b0;
                end else if (tx_cycle_expired[gi]) begin
                    evt_due_reg[gi] <= 1'b1;
                end else if (evt_take[gi]) begin
                    evt_due_reg[gi] <= 1'b0;
                end
            end

            always_ff @(posedge SYS_CLK) begin
                if (RST) begin
                    evt_last_reg[gi] <= fpdo_pkg::PAYLOAD_RST;
                end else if (evt_take[gi]) begin
                    evt_last_reg[gi] <= evt_tx_data[gi];
                end
            end
        end
    endgenerate

    // fixed priority: cyclic first, then event a, then event b
    assign buf_in_valid = OPERATIONAL && (cyc_pend_reg || (evt_req != '0));
    assign cyc_take     = buf_in_valid && buf_in_ready && cyc_pend_reg;
    assign evt_take[0]  = buf_in_valid && buf_in_ready && !cyc_pend_reg && evt_req[0];
    assign evt_take[1]  = buf_in_valid && buf_in_ready && !cyc_pend_reg && !evt_req[0]
                          && evt_req[1];

    always_comb begin
        buf_in_frame = '0;
        if (cyc_pend_reg) begin
            buf_in_frame.kind = fpdo_pkg::FPDO_TX_CYCLIC;
            buf_in_frame.data = cyc_payload_reg;
        end else if (evt_req[0]) begin
            buf_in_frame.kind = fpdo_pkg::FPDO_TX_EVENT_A;
            buf_in_frame.data = evt_tx_data[0];
        end else begin
            buf_in_frame.kind = fpdo_pkg::FPDO_TX_EVENT_B;
            buf_in_frame.data = evt_tx_data[1];
        end
    end

    // a stalled bus controller backs up into the arbiter; a new sync replaces a pending cyclic object, and event objects send their latest data
    fpdo_fifo #(.WIDTH(FW), .DEPTH(fpdo_pkg::BUF_DEPTH)) u_txbuf (
        .clk       (SYS_CLK),
        .rst       (RST),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in_frame),
        .out_valid (TX_VALID),
        .out_ready (TX_READY),
        .out_data  (TX_FRAME)
    );

    // ---------------- checks ----------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    a_sync_applies_rx: assert property (sync_hit |=> cyc_active_reg == $past(cyc_shadow_reg))
        else $error("sync did not apply cyclic rx data");
    a_cyc_rx_held: assert property (!sync_hit |=> $stable(cyc_active_reg))
        else $error("cyclic rx data changed without sync");
    a_sync_starts_tx: assert property (sync_hit |=> cyc_pend_reg && cyc_payload_reg[15:0]
                                       == $past(CYC_TX_SRC.status_word))
        else $error("sync did not start cyclic tx");
    a_sel_bits_lo: assert property (sync_hit && CYC_TX_SEL_LO == fpdo_pkg::FPDO_SRC_BITS
                                    |=> cyc_payload_reg[47:32] == $past(CYC_TX_SRC.bits[15:0]))
        else $error("cyclic tx source select wrong");
    a_evt_rx_now: assert property (evt_rx_hit[0] |=> EVT_RX_A.dword == $past(RX_FRAME.data[31:0])
                                   && EVT_RX_A.word4 == $past(RX_FRAME.data[63:48]))
        else $error("event rx a not taken at once");
    a_preop_quiet: assert property (!OPERATIONAL |-> !buf_in_valid ##1 !cyc_pend_reg)
        else $error("object offered while not operational");
    a_preop_ignore: assert property (RX_VALID && !OPERATIONAL |=> $stable(evt_rx_reg[1])
                                     && $stable(evt_rx_reg[0])
                                     && $stable(cyc_shadow_reg))
        else $error("telegram accepted while not operational");
    a_change_sends: assert property (OPERATIONAL && !cyc_pend_reg && buf_in_ready
                                     && evt_tx_data[0] != evt_last_reg[0]
                                     |-> evt_take[0] ##1 evt_last_reg[0] == $past(EVT_TX_A_DATA))
        else $error("changed event data not sent");
    a_cycle_due: assert property (OPERATIONAL && tx_cycle_expired[1] |=> evt_due_reg[1])
        else $error("cycle time did not request send");
    a_monitor_fault: assert property (OPERATIONAL && rx_mon_expired[0] |=> EVT_RX_A_FAULT)
        else $error("monitor timeout did not raise fault");
    a_views_agree: assert property (CYC_RX.bits == CYC_RX.dword
                                    && EVT_RX_B.bits == {EVT_RX_B.word2, EVT_RX_B.word1})
        else $error("bit, word and dword views disagree");

    c_sync_cycle: cover property (sync_hit ##[1:20] cyc_take);
    c_evt_send: cover property (evt_take[1]);
    c_fault: cover property (rx_fault_reg[0] ##1 evt_rx_hit[0]);
    c_buf_full: cover property (!buf_in_ready && buf_in_valid);
endmodule
`default_nettype wire

// *** fpdo_host.sv ***
// bus host model: takes outgoing telegrams, can stall
`timescale 1ns/1ns
`default_nettype none
module fpdo_host (
    input  wire logic                     clk,
    input  wire logic                     stall,
    input  wire logic                     tx_valid,
    output var  logic                     tx_ready,
    input  wire fpdo_pkg::fpdo_tx_frame_s tx_frame
);
    fpdo_pkg::fpdo_tx_frame_s got[$];
    initial tx_ready = 1'b0;
    // ready moves only just after an edge, so a word is never half taken
    always @(posedge clk) begin
        if (tx_valid && tx_ready)
            got.push_back(tx_frame);
        tx_ready <= !stall;
    end
endmodule
`default_nettype wire

// *** fpdo_interval.sv ***
// millisecond interval counter with restart and one-cycle expiry pulse
`timescale 1ns/1ns
`default_nettype none
module fpdo_interval #(
    parameter int unsigned TW = 16
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          tick,
    input  wire logic [TW-1:0] period,
    input  wire logic          restart,
    output var  logic          expired
);
    logic [TW-1:0] cnt_reg;

    if (TW < 2) begin : g_bad_tw
        $error("fpdo_interval: TW must be at least 2");
    end

    // a period of zero switches the interval off
    always_ff @(posedge clk) begin
        if (rst || restart) begin
            cnt_reg <= '0;
            expired <= 1'b0;
        end else if (tick && period != '0) begin
            if (cnt_reg + TW'(1) >= period) begin
                cnt_reg <= '0;
                expired <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + TW'(1);
                expired <= 1'b0;
            end
        end else begin
            expired <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** fpdo_pkg.sv ***
// shared constants, enums and carriers for the process data object framer
package fpdo_pkg;
    // timing: the cycle and monitoring settings count milliseconds
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned TIME_UNIT_NS  = 1000000;
    localparam int unsigned MS_CYCLES     = TIME_UNIT_NS / CLK_PERIOD_NS;
    localparam int unsigned TIME_W        = 16;

    // payload geometry, byte 1 of a telegram sits in bits 7:0
    localparam int unsigned PAYLOAD_BYTES = 8;
    localparam int unsigned PAYLOAD_W     = 8 * PAYLOAD_BYTES;
    localparam int unsigned EVT_OBJECTS   = 2;
    localparam int unsigned BUF_DEPTH     = 2;

    // field positions inside the 64-bit payload
    localparam int unsigned CTRL_LSB      = 0;
    localparam int unsigned CYC_W1_LSB    = 16;
    localparam int unsigned CYC_W2_LSB    = 32;
    localparam int unsigned CYC_W3_LSB    = 48;
    localparam int unsigned CYC_DW_LSB    = 32;
    localparam int unsigned EVT_W1_LSB    = 0;
    localparam int unsigned EVT_W2_LSB    = 16;
    localparam int unsigned EVT_W3_LSB    = 32;
    localparam int unsigned EVT_W4_LSB    = 48;
    localparam int unsigned EVT_DW_LSB    = 0;

    // values after reset
    localparam logic [63:0] PAYLOAD_RST   = 64'h0000_0000_0000_0000;
    localparam logic [15:0] TIME_RST      = 16'h0000;

    typedef enum logic [2:0] {
        FPDO_RX_SYNC,
        FPDO_RX_CYCLIC,
        FPDO_RX_EVENT_A,
        FPDO_RX_EVENT_B,
        FPDO_RX_OTHER
    } fpdo_rx_kind_e;

    typedef enum logic [1:0] {
        FPDO_TX_CYCLIC,
        FPDO_TX_EVENT_A,
        FPDO_TX_EVENT_B
    } fpdo_tx_kind_e;

    typedef enum logic [1:0] {
        FPDO_SRC_WORD,
        FPDO_SRC_BITS,
        FPDO_SRC_DWORD
    } fpdo_src_e;

    typedef struct packed {
        fpdo_rx_kind_e kind;
        logic [63:0]   data;
    } fpdo_rx_frame_s;

    typedef struct packed {
        fpdo_tx_kind_e kind;
        logic [63:0]   data;
    } fpdo_tx_frame_s;

    typedef struct packed {
        logic [15:0] ctrl_word;
        logic [15:0] word1;
        logic [15:0] word2;
        logic [15:0] word3;
        logic [31:0] bits;
        logic [31:0] dword;
    } fpdo_cyc_rx_s;

    typedef struct packed {
        logic [15:0] word1;
        logic [15:0] word2;
        logic [15:0] word3;
        logic [15:0] word4;
        logic [31:0] bits;
        logic [31:0] dword;
    } fpdo_evt_rx_s;

    typedef struct packed {
        logic [15:0] status_word;
        logic [15:0] word1;
        logic [15:0] word2;
        logic [15:0] word3;
        logic [31:0] bits;
        logic [31:0] dword;
    } fpdo_cyc_tx_src_s;
endpackage

// *** tb_fpdo_framer.sv ***
// self-checking bench for the process data object framer
`timescale 1ns/1ns
`default_nettype none
module tb_fpdo_framer;
    logic                       sys_clk, rst = 1, op = 0, rx_v = 0, stall = 0;
    logic                       tx_v, tx_r, fa, fb;
    logic [15:0]                ca = '0, cb = '0, ma = '0, mb = '0;
    logic [63:0]                ea = '0, eb = '0, d, e;
    logic [127:0]               prev = '0;
    fpdo_pkg::fpdo_rx_frame_s   rx_f = '0;
    fpdo_pkg::fpdo_tx_frame_s   tx_f, t;
    fpdo_pkg::fpdo_cyc_tx_src_s src = 128'h1234_5678_9abc_def0_1111_2222_3333_4444;
    fpdo_pkg::fpdo_src_e        lo = fpdo_pkg::FPDO_SRC_WORD, hi = fpdo_pkg::FPDO_SRC_WORD;
    fpdo_pkg::fpdo_cyc_rx_s     cyc;
    fpdo_pkg::fpdo_evt_rx_s     eva, evb;
    int                         error_cnt = 0;
    int                         comparisons = 0;
    fpdo_framer #(.MS_CYCLES(10)) i_dut (.SYS_CLK(sys_clk), .RST(rst), .OPERATIONAL(op),
        .RX_VALID(rx_v), .RX_FRAME(rx_f), .TX_VALID(tx_v), .TX_READY(tx_r), .TX_FRAME(tx_f),
        .CYC_TX_SRC(src), .CYC_TX_SEL_LO(lo), .CYC_TX_SEL_HI(hi), .EVT_TX_A_DATA(ea),
        .EVT_TX_B_DATA(eb), .EVT_TX_A_CYCLE_MS(ca), .EVT_TX_B_CYCLE_MS(cb),
        .EVT_RX_A_MONITOR_MS(ma), .EVT_RX_B_MONITOR_MS(mb), .CYC_RX(cyc), .EVT_RX_A(eva),
        .EVT_RX_B(evb), .EVT_RX_A_FAULT(fa), .EVT_RX_B_FAULT(fb));
    fpdo_host i_host (.clk(sys_clk), .stall(stall), .tx_valid(tx_v), .tx_ready(tx_r),
        .tx_frame(tx_f));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    function automatic logic [15:0] pick(int s, logic [15:0] w, b, x);
        return s == 0 ? w : s == 1 ? b : x;
    endfunction
    task automatic summarize();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [511:0] g, x);
        comparisons++;
        if (g !== x) begin
            error_cnt++;
            $display("ERROR %0t got %h", $time, g);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic send(fpdo_pkg::fpdo_rx_kind_e k, logic [63:0] x);
        @(posedge sys_clk);
        rx_v <= 1'b1;
        rx_f <= '{k, x};
        @(posedge sys_clk);
        rx_v <= 1'b0;
    endtask
    // words reach the host queue only through the handshake, so order is checked too
    task automatic pop(fpdo_pkg::fpdo_tx_kind_e k, logic [63:0] x);
        int n;
        n = 0;
        while (i_host.got.size() == 0) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n > 300) begin
                error_cnt++;
                summarize();
            end
        end
        t = i_host.got.pop_front();
        chk({t.kind, t.data}, {k, x});
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        send(fpdo_pkg::FPDO_RX_EVENT_A, 64'h1);
        tick(1);
        chk({tx_v, fa, fb, cyc, eva}, '0);
        $display("test idle done");
        @(posedge sys_clk);
        op <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            lo <= fpdo_pkg::fpdo_src_e'(i);
            hi <= fpdo_pkg::fpdo_src_e'(2 - i);
            d = 64'h8877_6655_4433_2211 + i;
            send(fpdo_pkg::FPDO_RX_CYCLIC, d);
            tick(1);
            chk(cyc, prev);
            send(fpdo_pkg::FPDO_RX_SYNC, '0);
            tick(1);
            prev = {d[15:0], d[31:16], d[47:32], d[63:48], d[63:32], d[63:32]};
            chk(cyc, prev);
            e[63:48] = pick(2 - i, src.word3, src.bits[31:16], src.dword[31:16]);
            e[47:0] = {pick(i, src.word2, src.bits[15:0], src.dword[15:0]), src.word1, src.status_word};
            pop(fpdo_pkg::FPDO_TX_CYCLIC, e);
        end
        send(fpdo_pkg::FPDO_RX_EVENT_A, d);
        send(fpdo_pkg::FPDO_RX_EVENT_B, ~d);
        send(fpdo_pkg::FPDO_RX_OTHER, 64'h0);
        tick(1);
        chk({eva, evb}, {prev[127:64], d[31:0], d[31:0], ~prev[127:64], ~d[31:0], ~d[31:0]});
        $display("test rx done");
        @(posedge sys_clk);
        stall <= 1'b1;
        ea <= 64'ha1;
        eb <= 64'hb1;
        repeat (4) @(posedge sys_clk);
        ea <= 64'ha2;
        tick(3);
        chk(tx_v, 1'b1); // full buffer keeps offering while stalled
        @(posedge sys_clk);
        stall <= 1'b0;
        pop(fpdo_pkg::FPDO_TX_EVENT_A, 64'ha1);
        pop(fpdo_pkg::FPDO_TX_EVENT_B, 64'hb1);
        pop(fpdo_pkg::FPDO_TX_EVENT_A, 64'ha2);
        @(posedge sys_clk);
        cb <= 16'h0003;
        pop(fpdo_pkg::FPDO_TX_EVENT_B, 64'hb1);
        @(posedge sys_clk);
        cb <= '0;
        ma <= 16'h0002;
        send(fpdo_pkg::FPDO_RX_EVENT_A, d);
        tick(8);
        chk({fa, fb}, 2'b00);
        tick(25);
        chk({fa, fb}, 2'b10);
        @(posedge sys_clk);
        ma <= '0;
        send(fpdo_pkg::FPDO_RX_EVENT_A, d);
        tick(1);
        chk(fa, 1'b0);
        $display("test tx and monitor done");
        summarize();
    end
endmodule
`default_nettype wire
